/* File: pkg/ext_bus_pkg.sv */
// Shared constants and types of the external parallel memory bus controller.
// Assumes one 25 MHz system clock; all counts are in clock or burst clock ticks.
package ext_bus_pkg;

	// ***************************************************
	// Widths
	// ***************************************************
	localparam int ADDR_W = 27; // 128MB byte space per chip select
	localparam int DATA_W = 32;
	localparam int PIN_W = 16;
	localparam int CNT_W = 5;
	localparam int UPPER_ADDR_BIT = 16;
	localparam int BEATS_W = 2;

	// ***************************************************
	// Encodings
	// ***************************************************
	localparam logic [1:0] DEV_W8 = 2'h0;
	localparam logic [1:0] DEV_W16 = 2'h1;
	localparam logic [1:0] DEV_W32 = 2'h2;
	localparam logic [1:0] SIZE_BYTE = 2'h0;
	localparam logic [1:0] SIZE_HALF = 2'h1;
	localparam logic [1:0] SIZE_WORD = 2'h2;
	localparam logic [1:0] DIV_1 = 2'h0;

	// ***************************************************
	// Pin levels and reset values
	// ***************************************************
	localparam logic PIN_IDLE = 1'b1;
	localparam logic [PIN_W-1:0] PIN_ZERO = 16'h0000;
	localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000;
	localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
	localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
	localparam logic [3:0] TURN_MIN = 4'h1;
	localparam logic [5:0] ACC_LEN_ZERO = 6'h00;
	localparam logic [5:0] ACC_LEN_ONE = 6'h01;

	typedef logic [CNT_W-1:0] cnt_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SETUP,
		ST_ACCESS,
		ST_HOLD,
		ST_TURN
	} bus_state_e;

endpackage

/* File: hdl/burst_clock_gen.sv */
// Burst clock divider for the external memory bus.
// Assumes run_in comes from a flop on the same clock; output parks low when idle.
`timescale 1ns/100ps
`default_nettype none
module burst_clock_gen import ext_bus_pkg::*; (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic clk_en_in,
	// Control
	input wire logic run_in,
	input wire logic [1:0] div_sel_in,
	// Clock out and rising-edge tick
	output logic bclk_out,
	output logic rise_tick_out
);
	logic [2:0] div_cnt_ff;
	logic [2:0] nxt_div_cnt;
	logic bclk_ff;
	logic nxt_bclk;
	logic [2:0] half_last;
	logic wrap;

	// Half period minus one: 0, 1 or 3 cycles for divide by 2, 4, 8
	always_comb begin
		// Four bits wide so that divide by 8 does not shift out to zero
		half_last = 3'(((4'h1 << div_sel_in) >> 1) - 4'h1);
		wrap = (div_sel_in == DIV_1) || (div_cnt_ff == half_last);
		nxt_div_cnt = div_cnt_ff;
		nxt_bclk = bclk_ff;
		if (!run_in) begin
			// Stopped between accesses to save power
			nxt_div_cnt = 3'h0;
			nxt_bclk = 1'b0;
		end else if (wrap) begin
			nxt_div_cnt = 3'h0;
			nxt_bclk = ~bclk_ff;
		end else begin
			nxt_div_cnt = div_cnt_ff + 3'h1;
		end
	end

	// Undivided mode ticks every cycle since a flop cannot follow the clock itself
	assign rise_tick_out = run_in && ((div_sel_in == DIV_1) || (wrap && !bclk_ff));
	assign bclk_out = bclk_ff;

	// State registers
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			div_cnt_ff <= 3'h0;
			bclk_ff <= 1'b0;
		end else if (clk_en_in) begin
			div_cnt_ff <= nxt_div_cnt;
			bclk_ff <= nxt_bclk;
		end
	end
endmodule // burst_clock_gen
`default_nettype wire

/* File: hdl/ext_mem_bus_ctrl.sv */
// External parallel memory bus controller: sequences split accesses on a
// shared 16-bit address/data bus with programmable phases.
// Assumes request and configuration ports are synchronous to sys_clk_in and
// that configuration stays stable while an access is in progress.
//
// Operation
// - 128MB address space per chip select
// - Device widths 8, 16, or 32 multiplexed
// - Byte enables for 16 and 32-bit devices
// - Counts in clock, or burst clock if sync
// - Separate read and write timing sets
// - Setup of 0 to 7 before strobe
// - Access strobe lasts 1 to 32 cycles
// - Later page accesses last 1 to 8
// - Hold of 0 to 7 after strobe
// - Turnaround of 1 to 15 between accesses
// - Page size 4, 8, 16 or 32
// - Burst clock is clock divided 2,2,4,8
// - Burst length 4, 8, 16 or 32
// - Burst clock stops while no access runs
// - Two strobe styles: OE/WE or RnW/enable
// - Lowest pin is address or byte enable
// - Shared lines driven only in own phase
// - Sync write and multiplexed 32-bit mode
// - Split requests to suit device width
// - Address valid usable on asynchronous cycles
// - Strobe delays follow programmed timing
// - Sync burst clock internal, 80 ns period or more
`timescale 1ns/100ps
`default_nettype none
module ext_mem_bus_ctrl import ext_bus_pkg::*; (
	// Clock, reset, enable
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic clk_en_in,
	// Request side
	input wire logic req_valid_in,
	input wire logic req_write_in,
	input wire logic req_cs_sel_in,
	input wire logic [1:0] req_size_in,
	input wire logic [ADDR_W-1:0] req_addr_in,
	input wire logic [DATA_W-1:0] req_wdata_in,
	output logic req_ready_out,
	output logic rsp_valid_out,
	output logic [DATA_W-1:0] rsp_rdata_out,
	// Configuration
	input wire logic [1:0] cfg_dev_width_in,
	input wire logic cfg_rnw_style_in,
	input wire logic cfg_sync_in,
	input wire logic cfg_addr_valid_async_in,
	input wire logic cfg_page_en_in,
	input wire logic [1:0] cfg_page_size_in,
	input wire logic cfg_burst_en_in,
	input wire logic [1:0] cfg_burst_len_in,
	input wire logic [1:0] cfg_burst_div_in,
	// Read timing set
	input wire logic [2:0] cfg_rd_setup_in,
	input wire logic [4:0] cfg_rd_access_in,
	input wire logic [2:0] cfg_rd_page_in,
	input wire logic [2:0] cfg_rd_hold_in,
	input wire logic [3:0] cfg_rd_turn_in,
	// Write timing set
	input wire logic [2:0] cfg_wr_setup_in,
	input wire logic [4:0] cfg_wr_access_in,
	input wire logic [2:0] cfg_wr_page_in,
	input wire logic [2:0] cfg_wr_hold_in,
	input wire logic [3:0] cfg_wr_turn_in,
	// Memory pins
	output logic chip_select_second_n_out,
	output logic chip_select_third_n_out,
	output logic low_address_or_byte_enable_out,
	output logic upper_address_line_out,
	output logic strobe_oe_n_rnw_out,
	output logic strobe_we_n_e_n_out,
	output logic address_valid_n_out,
	output logic burst_clock_out,
	output logic [PIN_W-1:0] bus_d_out,
	output logic bus_d_oe_n_out,
	input wire logic [PIN_W-1:0] bus_d_in,
	// Status
	output logic busy_out
);

	// ***************************************************
	// Helpers
	// ***************************************************

	// Address in device units
	function automatic logic [ADDR_W-1:0] unit_of(input logic [ADDR_W-1:0] a,
		input logic [1:0] w);
		unit_of = (w == DEV_W8) ? a : (a >> 1);
	endfunction

	// Beats needed for one request, minus one
	function automatic logic [BEATS_W-1:0] beats_of(input logic [1:0] sz,
		input logic [1:0] w);
		logic [2:0] b;
		b = (3'h1 << sz) >> ((w == DEV_W8) ? 0 : 1);
		beats_of = (b == 3'h0) ? 2'h0 : BEATS_W'(b - 3'h1);
	endfunction

	// Group mask for page size or burst length of 4, 8, 16, 32 units
	function automatic logic [CNT_W-1:0] grp_mask(input logic [1:0] sel);
		grp_mask = cnt_t'((6'h4 << sel) - 6'h1);
	endfunction

	// Countdown load from a one-based count field
	function automatic cnt_t less_one(input logic [3:0] v);
		less_one = (v == 4'h0) ? CNT_ZERO : cnt_t'(v - 4'h1);
	endfunction

	// ***************************************************
	// State
	// ***************************************************
	bus_state_e state_ff, nxt_state;
	cnt_t cnt_ff, nxt_cnt;
	logic [BEATS_W-1:0] beats_ff, nxt_beats;
	logic more_ff, nxt_more;
	logic [ADDR_W-1:0] addr_ff, nxt_addr;
	logic [DATA_W-1:0] wdata_ff, nxt_wdata;
	logic [DATA_W-1:0] rdata_ff, nxt_rdata;
	logic write_ff, nxt_write;
	logic cs_sel_ff, nxt_cs_sel;
	logic [1:0] size_ff, nxt_size;
	logic rsp_ff, nxt_rsp;
	logic ready_ff;
	logic cs_second_n_ff, cs_third_n_ff, be_ff, upa_ff, stra_ff, strb_ff;
	logic addr_valid_n_ff, d_oe_n_ff;
	logic nxt_cs_second_n, nxt_cs_third_n, nxt_be, nxt_upa, nxt_stra, nxt_strb;
	logic nxt_addr_valid_n, nxt_d_oe_n;
	logic [PIN_W-1:0] d_out_ff, nxt_d_out;
	logic [PIN_W-1:0] ds1_ff, ds2_ff, ds3_ff, filt_ff;
	logic tick, bclk_rise, dir, seq_en;
	logic [2:0] t_setup, t_page, t_hold;
	logic [4:0] t_acc;
	logic [3:0] t_turn;
	logic [ADDR_W-1:0] step_addr, nxt_unit;
	logic [5:0] acc_len_ff;

	// Burst clock made internally, stopped while idle
	burst_clock_gen u_bclk (
		.sys_clk_in(sys_clk_in),
		.rst_n_in(rst_n_in),
		.clk_en_in(clk_en_in),
		.run_in(state_ff != ST_IDLE),
		.div_sel_in(cfg_burst_div_in),
		.bclk_out(burst_clock_out),
		.rise_tick_out(bclk_rise)
	);

	// Timing set follows the direction of the access in hand
	always_comb begin
		dir = (state_ff == ST_IDLE) ? req_write_in : write_ff;
		t_setup = dir ? cfg_wr_setup_in : cfg_rd_setup_in;
		t_acc = dir ? cfg_wr_access_in : cfg_rd_access_in;
		t_page = dir ? cfg_wr_page_in : cfg_rd_page_in;
		t_hold = dir ? cfg_wr_hold_in : cfg_rd_hold_in;
		t_turn = dir ? cfg_wr_turn_in : cfg_rd_turn_in;
		// Phases advance on clock, or on burst clock rises in sync mode
		tick = cfg_sync_in ? bclk_rise : 1'b1;
		// Page, burst and multiplexed wide beats stay in one strobe group
		seq_en = cfg_page_en_in || cfg_burst_en_in || (cfg_dev_width_in == DEV_W32);
		step_addr = addr_ff + ((cfg_dev_width_in == DEV_W8) ? 27'h1 : 27'h2);
		nxt_unit = unit_of(step_addr, cfg_dev_width_in);
	end

	// ***************************************************
	// Access sequencer
	// ***************************************************

	// Next state of the access sequence
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_beats = beats_ff;
		nxt_more = more_ff;
		nxt_addr = addr_ff;
		nxt_wdata = wdata_ff;
		nxt_rdata = rdata_ff;
		nxt_write = write_ff;
		nxt_cs_sel = cs_sel_ff;
		nxt_size = size_ff;
		nxt_rsp = 1'b0;
		unique case (state_ff)
			ST_IDLE: begin
				if (req_valid_in && ready_ff) begin
					nxt_addr = req_addr_in;
					nxt_wdata = req_wdata_in;
					nxt_write = req_write_in;
					nxt_cs_sel = req_cs_sel_in;
					nxt_size = req_size_in;
					nxt_rdata = WORD_ZERO;
					nxt_beats = beats_of(req_size_in, cfg_dev_width_in);
					// Zero setup puts the strobe out at once
					nxt_state = (t_setup == 3'h0) ? ST_ACCESS : ST_SETUP;
					nxt_cnt = (t_setup == 3'h0) ? t_acc : less_one({1'b0, t_setup});
				end
			end
			ST_SETUP: begin
				if (tick && cnt_ff == CNT_ZERO) begin
					nxt_state = ST_ACCESS;
					nxt_cnt = t_acc;
				end else if (tick) begin
					nxt_cnt = cnt_ff - CNT_ONE;
				end
			end
			ST_ACCESS: begin
				if (tick && cnt_ff == CNT_ZERO) begin
					// Read beat lands in its lane of the word
					if (!write_ff) begin
						if (cfg_dev_width_in == DEV_W8) begin
							nxt_rdata[addr_ff[1:0]*8 +: 8] = filt_ff[7:0];
						end else begin
							nxt_rdata[addr_ff[1]*16 +: 16] = filt_ff;
						end
					end
					nxt_more = (beats_ff != 2'h0);
					if (beats_ff != 2'h0) begin
						nxt_beats = beats_ff - 2'h1;
						nxt_addr = step_addr;
					end
					if (beats_ff != 2'h0 && seq_en
						&& (nxt_unit[CNT_W-1:0] & grp_mask(cfg_page_en_in
						? cfg_page_size_in : cfg_burst_len_in)) != CNT_ZERO) begin
						nxt_state = ST_ACCESS;
						nxt_cnt = cnt_t'(t_page);
					end else if (t_hold != 3'h0) begin
						nxt_state = ST_HOLD;
						nxt_cnt = less_one({1'b0, t_hold});
					end else begin
						nxt_state = ST_TURN;
						nxt_cnt = less_one(t_turn < TURN_MIN ? TURN_MIN : t_turn);
					end
				end else if (tick) begin
					nxt_cnt = cnt_ff - CNT_ONE;
				end
			end
			ST_HOLD: begin
				if (tick && cnt_ff == CNT_ZERO) begin
					nxt_state = ST_TURN;
					nxt_cnt = less_one(t_turn < TURN_MIN ? TURN_MIN : t_turn);
				end else if (tick) begin
					nxt_cnt = cnt_ff - CNT_ONE;
				end
			end
			ST_TURN: begin
				if (tick && cnt_ff == CNT_ZERO) begin
					if (more_ff) begin
						nxt_more = 1'b0;
						nxt_state = (t_setup == 3'h0) ? ST_ACCESS : ST_SETUP;
						nxt_cnt = (t_setup == 3'h0) ? t_acc : less_one({1'b0, t_setup});
					end else begin
						nxt_state = ST_IDLE;
						nxt_rsp = 1'b1;
					end
				end else if (tick) begin
					nxt_cnt = cnt_ff - CNT_ONE;
				end
			end
		endcase
	end

	// Pin levels follow the next state so they line up with it
	always_comb begin
		logic act;
		logic strobe_on;
		logic [ADDR_W-1:0] unit_a;
		act = (nxt_state == ST_SETUP) || (nxt_state == ST_ACCESS) || (nxt_state == ST_HOLD);
		strobe_on = (nxt_state == ST_ACCESS);
		unit_a = unit_of(nxt_addr, cfg_dev_width_in);
		nxt_cs_second_n = !(act && !nxt_cs_sel);
		nxt_cs_third_n = !(act && nxt_cs_sel);
		if (cfg_rnw_style_in) begin
			nxt_stra = !(act && nxt_write);
			nxt_strb = !strobe_on;
		end else begin
			nxt_stra = !(strobe_on && !nxt_write);
			nxt_strb = !(strobe_on && nxt_write);
		end
		nxt_addr_valid_n = !((nxt_state == ST_SETUP)
			&& (cfg_sync_in || cfg_addr_valid_async_in));
		// Upper lane enable for wide devices, plain address bit otherwise
		if (cfg_dev_width_in == DEV_W8) begin
			nxt_be = nxt_addr[0];
		end else begin
			nxt_be = !((nxt_size != SIZE_BYTE) || nxt_addr[0]);
		end
		nxt_upa = act && unit_a[UPPER_ADDR_BIT];
		nxt_d_out = PIN_ZERO;
		nxt_d_oe_n = PIN_IDLE;
		if (nxt_state == ST_SETUP) begin
			nxt_d_out = unit_a[PIN_W-1:0];
			nxt_d_oe_n = 1'b0;
		end else if (strobe_on && nxt_write) begin
			nxt_d_out = nxt_wdata[nxt_addr[1]*16 +: 16];
			if (cfg_dev_width_in == DEV_W8) begin
				nxt_d_out = {8'h00, nxt_wdata[nxt_addr[1:0]*8 +: 8]};
			end
			nxt_d_oe_n = 1'b0;
		end
	end

	// Sequencer and pin registers
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_ff <= ST_IDLE;
			cnt_ff <= CNT_ZERO;
			beats_ff <= 2'h0;
			more_ff <= 1'b0;
			addr_ff <= 27'h0;
			wdata_ff <= WORD_ZERO;
			rdata_ff <= WORD_ZERO;
			write_ff <= 1'b0;
			cs_sel_ff <= 1'b0;
			size_ff <= SIZE_BYTE;
			rsp_ff <= 1'b0;
			ready_ff <= 1'b0;
			cs_second_n_ff <= PIN_IDLE;
			cs_third_n_ff <= PIN_IDLE;
			be_ff <= PIN_IDLE;
			upa_ff <= 1'b0;
			stra_ff <= PIN_IDLE;
			strb_ff <= PIN_IDLE;
			addr_valid_n_ff <= PIN_IDLE;
			d_out_ff <= PIN_ZERO;
			d_oe_n_ff <= PIN_IDLE;
		end else if (clk_en_in) begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			beats_ff <= nxt_beats;
			more_ff <= nxt_more;
			addr_ff <= nxt_addr;
			wdata_ff <= nxt_wdata;
			rdata_ff <= nxt_rdata;
			write_ff <= nxt_write;
			cs_sel_ff <= nxt_cs_sel;
			size_ff <= nxt_size;
			rsp_ff <= nxt_rsp;
			ready_ff <= (nxt_state == ST_IDLE);
			cs_second_n_ff <= nxt_cs_second_n;
			cs_third_n_ff <= nxt_cs_third_n;
			be_ff <= nxt_be;
			upa_ff <= nxt_upa;
			stra_ff <= nxt_stra;
			strb_ff <= nxt_strb;
			addr_valid_n_ff <= nxt_addr_valid_n;
			d_out_ff <= nxt_d_out;
			d_oe_n_ff <= nxt_d_oe_n;
		end
	end

	// ***************************************************
	// Read data synchroniser
	// ***************************************************

	// Pin data passes three flops; a value counts once the last two agree
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ds1_ff <= PIN_ZERO;
			ds2_ff <= PIN_ZERO;
			ds3_ff <= PIN_ZERO;
			filt_ff <= PIN_ZERO;
		end else if (clk_en_in) begin
			ds1_ff <= bus_d_in;
			ds2_ff <= ds1_ff;
			ds3_ff <= ds2_ff;
			filt_ff <= (ds2_ff == ds3_ff) ? ds3_ff : filt_ff;
		end
	end

	// Output wiring, all from flops
	assign req_ready_out = ready_ff;
	assign rsp_valid_out = rsp_ff;
	assign rsp_rdata_out = rdata_ff;
	assign chip_select_second_n_out = cs_second_n_ff;
	assign chip_select_third_n_out = cs_third_n_ff;
	assign low_address_or_byte_enable_out = be_ff;
	assign upper_address_line_out = upa_ff;
	assign strobe_oe_n_rnw_out = stra_ff;
	assign strobe_we_n_e_n_out = strb_ff;
	assign address_valid_n_out = addr_valid_n_ff;
	assign bus_d_out = d_out_ff;
	assign bus_d_oe_n_out = d_oe_n_ff;
	assign busy_out = !ready_ff;

	// ***************************************************
	// Assertions
	// ***************************************************
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in || !clk_en_in);

	// Strobe run length in unsynchronised mode
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			acc_len_ff <= ACC_LEN_ZERO;
		end else if (clk_en_in) begin
			acc_len_ff <= (state_ff == ST_ACCESS && cnt_ff != CNT_ZERO) ? acc_len_ff + ACC_LEN_ONE
				: ACC_LEN_ZERO;
		end
	end

	sequence s_idle_twice;
		state_ff == ST_IDLE ##1 state_ff == ST_IDLE;
	endsequence
	sequence s_hold_to_turn;
		state_ff == ST_HOLD ##1 state_ff == ST_TURN;
	endsequence

	a_burst_clk_stop: assert property (s_idle_twice |-> !burst_clock_out)
		else $error("burst clock running while idle");
	a_access_len: assert property (!cfg_sync_in |-> acc_len_ff <= {1'b0, t_acc})
		else $error("strobe held longer than access count");
	a_setup_quiet: assert property (state_ff == ST_SETUP && !cfg_rnw_style_in
		|-> stra_ff && strb_ff && !(cs_second_n_ff && cs_third_n_ff))
		else $error("strobe active during setup");
	a_hold_phase: assert property (s_hold_to_turn |-> cs_second_n_ff && cs_third_n_ff
		&& $past(!(cs_second_n_ff && cs_third_n_ff)) && $past(strb_ff))
		else $error("hold phase pin levels wrong");
	a_turn_release: assert property (state_ff == ST_TURN
		|-> d_oe_n_ff && cs_second_n_ff && cs_third_n_ff)
		else $error("bus driven during turnaround");
	a_bus_owner: assert property (state_ff == ST_ACCESS |-> d_oe_n_ff == !write_ff)
		else $error("data bus drive does not match direction");
	a_adv_async: assert property (state_ff == ST_SETUP && cfg_addr_valid_async_in
		|-> !addr_valid_n_ff)
		else $error("address valid missing in setup");
	a_byte_enable: assert property (state_ff == ST_ACCESS && cfg_dev_width_in != DEV_W8
		&& size_ff == SIZE_WORD |-> !be_ff)
		else $error("upper byte enable not asserted");
	a_rsp_after_turn: assert property (rsp_ff |-> ready_ff && $past(state_ff == ST_TURN))
		else $error("response outside end of sequence");
endmodule // ext_mem_bus_ctrl
`default_nettype wire

/* File: verification/ext_mem_partner.sv */
// Behavioural 16-bit external memory that answers on the shared bus lines.
// Assumes the controller pins are registered on the same system clock.
`timescale 1ns/100ps
`default_nettype none
module ext_mem_partner (
	// Strobe style and controller pins
	input wire logic clk_in,
	input wire logic rnw_style_in,
	input wire logic cs_second_n_in,
	input wire logic cs_third_n_in,
	input wire logic be_in,
	input wire logic upper_in,
	input wire logic oe_rnw_in,
	input wire logic we_e_in,
	input wire logic [15:0] d_in,
	input wire logic d_oe_n_in,
	// Data lines back to the controller
	output logic [15:0] d_out
);
	// ******
	// Storage and decode
	// ******
	logic [15:0] mem [int];
	int key = 0;
	logic seen = 1'b0;
	logic rd;
	logic wr;
	// Strobe decode for both pin styles
	assign rd = rnw_style_in ? (!we_e_in && oe_rnw_in) : !oe_rnw_in;
	assign wr = rnw_style_in ? (!we_e_in && !oe_rnw_in) : !we_e_in;
	// Address latched only before the strobe, so held write data is not taken as address
	always @(negedge clk_in) begin
		if (cs_second_n_in && cs_third_n_in)
			seen = 1'b0;
		else if (rd || wr)
			seen = 1'b1;
		else if (!d_oe_n_in && !seen)
			key = int'({cs_third_n_in, be_in, upper_in, d_in});
		if (wr && !d_oe_n_in)
			mem[key] = d_in;
	end
	// Lines have pull-downs, so released lines read as zero
	assign d_out = (rd && mem.exists(key)) ? mem[key] : 16'h0000;
endmodule // ext_mem_partner
`default_nettype wire

/* File: verification/tb_external_parallel_memory_bus.sv */
// Self-checking bench: random round trips through the controller and a byte model.
// Assumes the partner memory answers reads inside the access phase.
`timescale 1ns/100ps
`default_nettype none
module tb_external_parallel_memory_bus import ext_bus_pkg::*;;
	// ******
	// Pins and bench state
	// ******
	logic sys_clk_in = 1'b0;
	logic rst_n_in, clk_en_in, req_valid_in, req_write_in, req_cs_sel_in, cfg_rnw_style_in;
	logic cfg_sync_in, cfg_addr_valid_async_in, cfg_page_en_in, cfg_burst_en_in;
	logic [1:0] req_size_in, cfg_dev_width_in, cfg_page_size_in, cfg_burst_len_in, cfg_burst_div_in;
	logic [ADDR_W-1:0] req_addr_in, a;
	logic [DATA_W-1:0] req_wdata_in, rsp_rdata_out;
	logic [2:0] cfg_rd_setup_in, cfg_rd_page_in, cfg_rd_hold_in;
	logic [2:0] cfg_wr_setup_in, cfg_wr_page_in, cfg_wr_hold_in;
	logic [4:0] cfg_rd_access_in, cfg_wr_access_in;
	logic [3:0] cfg_rd_turn_in, cfg_wr_turn_in;
	logic req_ready_out, rsp_valid_out, chip_select_second_n_out, chip_select_third_n_out;
	logic low_address_or_byte_enable_out, upper_address_line_out, strobe_oe_n_rnw_out;
	logic strobe_we_n_e_n_out, address_valid_n_out, burst_clock_out, bus_d_oe_n_out, busy_out;
	logic [PIN_W-1:0] bus_d_out, bus_d_in;
	logic [15:0] lfsr = 16'h0055;
	logic [7:0] mdl [int];
	logic [1:0] sz;
	int err_total = 0, samples_checked = 0, pre = 0, run = 0, post = 0;
	logic seen_st = 1'b0, act, cur_w = 1'b0, cur_sel = 1'b0;
	logic [5:0] e_set, e_acc, e_hold;

	always #20 sys_clk_in = !sys_clk_in;

	ext_mem_bus_ctrl u_dut (
		.sys_clk_in, .rst_n_in, .clk_en_in, .req_valid_in, .req_write_in, .req_cs_sel_in,
		.req_size_in, .req_addr_in, .req_wdata_in, .req_ready_out, .rsp_valid_out, .rsp_rdata_out,
		.cfg_dev_width_in, .cfg_rnw_style_in, .cfg_sync_in, .cfg_addr_valid_async_in,
		.cfg_page_en_in,
		.cfg_page_size_in, .cfg_burst_en_in, .cfg_burst_len_in, .cfg_burst_div_in,
		.cfg_rd_setup_in, .cfg_rd_access_in, .cfg_rd_page_in, .cfg_rd_hold_in, .cfg_rd_turn_in,
		.cfg_wr_setup_in, .cfg_wr_access_in, .cfg_wr_page_in, .cfg_wr_hold_in, .cfg_wr_turn_in,
		.chip_select_second_n_out, .chip_select_third_n_out, .low_address_or_byte_enable_out,
		.upper_address_line_out, .strobe_oe_n_rnw_out, .strobe_we_n_e_n_out,
		.address_valid_n_out, .burst_clock_out, .bus_d_out, .bus_d_oe_n_out, .bus_d_in, .busy_out
	);

	ext_mem_partner u_mem (
		.clk_in(sys_clk_in), .rnw_style_in(cfg_rnw_style_in),
		.cs_second_n_in(chip_select_second_n_out),
		.cs_third_n_in(chip_select_third_n_out), .be_in(low_address_or_byte_enable_out),
		.upper_in(upper_address_line_out), .oe_rnw_in(strobe_oe_n_rnw_out),
		.we_e_in(strobe_we_n_e_n_out), .d_in(bus_d_out), .d_oe_n_in(bus_d_oe_n_out), .d_out(bus_d_in)
	);

	// ******
	// Checking helpers
	// ******
	function automatic logic [15:0] lfsr_next(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic summarize();
		$display("checks %0d errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Strobe active in either pin style
	assign act = cfg_rnw_style_in ? !strobe_we_n_e_n_out
		: !(strobe_oe_n_rnw_out && strobe_we_n_e_n_out);

	// Phase monitor; burst clock ticks make lengths unfixed in sync mode, so skipped there
	always @(negedge sys_clk_in) begin
		if (!(cur_sel ? chip_select_third_n_out : chip_select_second_n_out) && !cfg_sync_in) begin
			if (act) begin
				if (!seen_st)
					check(pre, e_set);
				check({strobe_oe_n_rnw_out, strobe_we_n_e_n_out, bus_d_oe_n_out,
					cur_sel ? chip_select_second_n_out : chip_select_third_n_out},
					{cfg_rnw_style_in != cur_w, !cfg_rnw_style_in && !cur_w, !cur_w, 1'b1});
				run++;
				seen_st = 1'b1;
			end else if (!seen_st) begin
				check(address_valid_n_out, !cfg_addr_valid_async_in);
				pre++;
			end else begin
				if (run != 0)
					check(run, e_acc);
				run = 0;
				post++;
			end
		end else begin
			if (seen_st && run != 0)
				check(run, e_acc);
			if (seen_st)
				check(post, e_hold);
			pre = 0;
			run = 0;
			post = 0;
			seen_st = 1'b0;
		end
	end

	// One request; latency checked in unsynchronised mode, read data against the byte model
	task automatic xfer(input logic w, input logic s, input logic [DATA_W-1:0] d);
		int n, nb, lat, key, ln;
		logic [DATA_W-1:0] e, m;
		@(negedge sys_clk_in);
		check(burst_clock_out, 1'b0);
		cur_w = w;
		cur_sel = s;
		e_set = w ? cfg_wr_setup_in : cfg_rd_setup_in;
		e_acc = (w ? cfg_wr_access_in : cfg_rd_access_in) + 6'h01;
		e_hold = w ? cfg_wr_hold_in : cfg_rd_hold_in;
		n = w ? cfg_wr_turn_in : cfg_rd_turn_in;
		nb = 1 << sz;
		lat = (cfg_dev_width_in == DEV_W8) ? nb : ((sz == SIZE_WORD) ? 2 : 1);
		lat = lat * (e_set + e_acc + e_hold + ((n == 0) ? 1 : n));
		{req_valid_in, req_write_in, req_cs_sel_in, req_size_in, req_addr_in, req_wdata_in} = {1'b1, w, s, sz, a, d};
		n = 0;
		while (req_ready_out !== 1'b1 && n < 50) begin
			@(negedge sys_clk_in);
			n++;
		end
		@(negedge sys_clk_in);
		req_valid_in = 1'b0;
		// A request never taken counts as a timeout
		n = (n >= 50) ? 4000 : 0;
		while (rsp_valid_out !== 1'b1 && n < 4000) begin
			@(negedge sys_clk_in);
			n++;
		end
		if (n >= 4000 || n < 0) begin
			err_total++;
			summarize();
		end
		if (!cfg_sync_in)
			check(n, lat);
		e = WORD_ZERO;
		m = WORD_ZERO;
		for (int k = 0; k < nb; k++) begin
			key = (int'(s) << 28) + int'(a) + k;
			ln = 8 * ((int'(a[1:0]) + k) % 4);
			if (w)
				mdl[key] = d[ln +: 8];
			else begin
				e[ln +: 8] = mdl.exists(key) ? mdl[key] : 8'h00;
				m[ln +: 8] = 8'hFF;
			end
		end
		if (!w)
			check(rsp_rdata_out & m, e);
	endtask

	// ******
	// Main sequence
	// ******
	initial begin
		{rst_n_in, req_valid_in, req_write_in, req_cs_sel_in, req_size_in, req_addr_in, req_wdata_in} = '0;
		{cfg_dev_width_in, cfg_rnw_style_in, cfg_sync_in, cfg_addr_valid_async_in} = '0;
		cfg_page_en_in = 1'b0;
		{cfg_page_size_in, cfg_burst_en_in, cfg_burst_len_in, cfg_burst_div_in} = '0;
		{cfg_rd_setup_in, cfg_rd_access_in, cfg_rd_page_in, cfg_rd_hold_in, cfg_rd_turn_in} = '0;
		{cfg_wr_setup_in, cfg_wr_access_in, cfg_wr_page_in, cfg_wr_hold_in, cfg_wr_turn_in} = '0;
		clk_en_in = 1'b1;
		repeat (16) @(negedge sys_clk_in);
		// Idle pin levels while reset is held
		check({chip_select_second_n_out, chip_select_third_n_out, strobe_oe_n_rnw_out,
			strobe_we_n_e_n_out, bus_d_oe_n_out, req_ready_out}, 6'h3E);
		rst_n_in = 1'b1;
		repeat (2) @(negedge sys_clk_in);
		for (int i = 0; i < 20; i++) begin
			lfsr = lfsr_next(lfsr);
			cfg_dev_width_in = lfsr[0] ? DEV_W16 : DEV_W8;
			{cfg_rnw_style_in, cfg_addr_valid_async_in, cfg_burst_div_in} = lfsr[4:1];
			cfg_sync_in = (i % 5 == 4);
			{cfg_page_size_in, cfg_burst_len_in} = lfsr[8:5];
			cfg_rd_setup_in = (i == 0) ? 3'h7 : {1'b0, lfsr[10:9]} + 3'h1;
			cfg_rd_access_in = (i == 1) ? 5'h1F : {2'h0, lfsr[13:11]} + 5'h05;
			cfg_rd_hold_in = {1'b0, lfsr[15:14]};
			cfg_rd_page_in = lfsr[2:0];
			lfsr = lfsr_next(lfsr);
			cfg_rd_turn_in = lfsr[3:0];
			cfg_wr_turn_in = (i == 2) ? 4'hF : lfsr[7:4];
			cfg_wr_setup_in = {1'b0, lfsr[9:8]} + 3'h1;
			cfg_wr_access_in = {2'h0, lfsr[12:10]} + 5'h05;
			cfg_wr_hold_in = {1'b0, lfsr[14:13]} + 3'h1;
			cfg_wr_page_in = lfsr[2:0];
			lfsr = lfsr_next(lfsr);
			sz = (cfg_dev_width_in == DEV_W8) ? 2'(lfsr[1:0] % 3) : {1'b0, lfsr[0]} + 2'h1;
			a = {10'h000, lfsr[5], lfsr} & ~((27'h1 << sz) - 27'h1);
			xfer(1'b1, 1'b0, {lfsr, lfsr_next(lfsr)});
			xfer(1'b0, 1'b0, WORD_ZERO);
			xfer(1'b0, 1'b1, WORD_ZERO);
		end
		summarize();
	end
endmodule // tb_external_parallel_memory_bus
`default_nettype wire
